// >>> sfwg_core.v
// write guard, block protection and pause logic of a serial flash
`timescale 1ns/10ps
`include "sfwg_defines.vh"
module sfwg_core #(
    parameter BUSY_CYCLES = 16,
    parameter UNIFORM_64K = 1
) (
    input wire clk,
    input wire resetn,
    input wire chip_select_n,
    input wire serial_clk,
    input wire serial_in,
    input wire pause_n_pin,
    input wire write_guard_pin,
    input wire status_out_bit,
    output reg serial_out,
    output reg serial_out_en,
    output reg [7:0] status_reg,
    output reg [7:0] config_reg,
    output reg paused,
    output reg busy,
    output reg prog_start,
    output reg erase_start,
    output reg [7:0] op_cmd,
    output reg [23:0] op_addr,
    output reg cmd_refused,
    output reg fast_prog_active
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    // active-low pins travel inverted so the cleared flops match their idle level
    wire [4:0] pins_s;
    sfwg_sync #(.W(5)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({~chip_select_n, serial_clk, serial_in, ~pause_n_pin, ~write_guard_pin}),
        .q(pins_s)
    );
    wire cs_n = ~pins_s[4];
    wire sck = pins_s[3];
    wire sdi = pins_s[2];
    wire pause_pin = ~pins_s[1];
    wire guard_pin = ~pins_s[0];
    reg cs_n_d_reg;
    reg sck_d_reg;
    reg pause_d_reg;
    wire sck_rise = sck & ~sck_d_reg;
    wire sck_fall = ~sck & sck_d_reg;
    wire cs_rise = cs_n & ~cs_n_d_reg;
    wire quad = config_reg[`SFWG_CF_QUAD];
    // ****************************************
    // pause state
    // ****************************************
    reg pend_enter_reg;
    reg pend_exit_reg;
    wire pause_fall = ~pause_pin & pause_d_reg;
    wire pause_rise = pause_pin & ~pause_d_reg;
    // output must drop in the same cycle the pause begins
    wire pause_enter = !quad && !cs_n && !paused && ((pause_fall && !sck) ||
        (!pause_fall && pend_enter_reg && !pause_pin && sck_fall));
    always @(posedge clk) begin
        if (!resetn) begin
            paused <= 1'b0;
            pend_enter_reg <= 1'b0;
            pend_exit_reg <= 1'b0;
        end else if (quad || cs_n) begin
            // pause has no meaning in quad mode or when deselected
            paused <= 1'b0;
            pend_enter_reg <= 1'b0;
            pend_exit_reg <= 1'b0;
        end else if (!paused) begin
            if (pause_fall && !sck) begin
                paused <= 1'b1;
            end else if (pause_fall) begin
                pend_enter_reg <= 1'b1;
            end else if (pend_enter_reg && pause_pin) begin
                pend_enter_reg <= 1'b0;
            end else if (pend_enter_reg && sck_fall) begin
                paused <= 1'b1;
                pend_enter_reg <= 1'b0;
            end
        end else begin
            if (pause_rise && !sck) begin
                paused <= 1'b0;
            end else if (pause_rise) begin
                pend_exit_reg <= 1'b1;
            end else if (pend_exit_reg && sck_fall) begin
                paused <= 1'b0;
                pend_exit_reg <= 1'b0;
            end
        end
    end
    // ****************************************
    // serial shifter
    // ****************************************
    reg [7:0] shift_reg;
    reg [15:0] bit_cnt_reg;
    reg [7:0] cmd_reg;
    reg [23:0] addr_reg;
    reg [7:0] data_reg;
    // clock and data ignored while paused
    wire take_bit = sck_rise && !cs_n && !paused;
    wire [7:0] shift_next = {shift_reg[6:0], sdi};
    always @(posedge clk) begin
        if (!resetn || cs_n) begin
            // deselect drops any partial command, even one held by pause
            shift_reg <= 8'h00;
            bit_cnt_reg <= 16'h0000;
            cmd_reg <= 8'h00;
            addr_reg <= 24'h00_0000;
            data_reg <= 8'h00;
        end else if (take_bit) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 16'h0001;
            if (bit_cnt_reg[2:0] == 3'd7) begin
                case (bit_cnt_reg[15:3])
                    13'd0: cmd_reg <= shift_next;
                    13'd1: addr_reg[23:16] <= shift_next;
                    13'd2: addr_reg[15:8] <= shift_next;
                    13'd3: addr_reg[7:0] <= shift_next;
                    default: data_reg <= shift_next;
                endcase
                if (bit_cnt_reg[15:3] == 13'd1 && cmd_reg == `SFWG_CMD_REG_WRITE) begin
                    data_reg <= shift_next;
                end
            end
        end
    end
    // ****************************************
    // block protection decode
    // ****************************************
    wire [2:0] guard = status_reg[`SFWG_ST_GUARD_LO+2:`SFWG_ST_GUARD_LO];
    reg hit;
    reg [23:0] span;
    always @* begin
        // region size doubles with each code: 256 KB << (code-1)
        span = (`SFWG_BOT_1_64_END + 24'h00_0001) << (guard - 3'd1);
        if (guard == 3'b000) begin
            hit = 1'b0;
        end else if (guard == 3'b111) begin
            hit = 1'b1;
        end else if (config_reg[`SFWG_CF_ORIGIN]) begin
            hit = (addr_reg <= span - 24'h00_0001);
        end else begin
            hit = (addr_reg >= 24'h00_0000 - span);
        end
    end
    wire bulk_hit = (guard != 3'b000); // bulk erase touches every region
    // ****************************************
    // command completion at deselect
    // ****************************************
    wire latch = status_reg[`SFWG_ST_LATCH];
    wire whole = (bit_cnt_reg[2:0] == 3'd0);
    wire is_prog = cmd_reg == `SFWG_CMD_PAGE_PROG || cmd_reg == `SFWG_CMD_QUAD_PROG ||
        cmd_reg == `SFWG_CMD_OTP_PROG;
    wire is_param = cmd_reg == `SFWG_CMD_P4K_ERASE || cmd_reg == `SFWG_CMD_P8K_ERASE;
    wire is_erase = cmd_reg == `SFWG_CMD_SECT_ERASE || is_param ||
        cmd_reg == `SFWG_CMD_BULK_ERASE;
    wire hw_locked = status_reg[`SFWG_ST_LOCK] && !guard_pin && !quad;
    wire frozen = config_reg[`SFWG_CF_FREEZE];
    wire ready = cs_rise && bit_cnt_reg >= 16'd8 && whole && !busy;
    wire prot = (cmd_reg == `SFWG_CMD_BULK_ERASE) ? bulk_hit : hit;
    localparam [15:0] BUSY_LOAD = BUSY_CYCLES[15:0];
    reg [15:0] busy_cnt_reg;
    reg [7:0] cur_cmd_reg;
    always @(posedge clk) begin
        if (!resetn) begin
            status_reg <= `SFWG_ST_RESET; // latch clear at power up
            config_reg <= `SFWG_CF_RESET;
            busy <= 1'b0;
            busy_cnt_reg <= 16'h0000;
            cur_cmd_reg <= 8'h00;
            prog_start <= 1'b0;
            erase_start <= 1'b0;
            op_cmd <= 8'h00;
            op_addr <= 24'h00_0000;
            cmd_refused <= 1'b0;
        end else begin
            prog_start <= 1'b0;
            erase_start <= 1'b0;
            cmd_refused <= 1'b0;
            // internal operation runs on whatever the serial side does
            if (busy) begin
                if (busy_cnt_reg == 16'h0001) begin
                    busy <= 1'b0;
                    status_reg[`SFWG_ST_LATCH] <= 1'b0;
                end
                busy_cnt_reg <= busy_cnt_reg - 16'h0001;
            end
            if (ready && bit_cnt_reg == 16'd8) begin
                if (cmd_reg == `SFWG_CMD_WRITE_UNLOCK) begin
                    status_reg[`SFWG_ST_LATCH] <= 1'b1;
                end else if (cmd_reg == `SFWG_CMD_WRITE_LOCK) begin
                    status_reg[`SFWG_ST_LATCH] <= 1'b0;
                end else if (cmd_reg == `SFWG_CMD_BULK_ERASE && latch) begin
                    if (bulk_hit) begin
                        cmd_refused <= 1'b1;
                    end else begin
                        erase_start <= 1'b1;
                        op_cmd <= cmd_reg;
                        op_addr <= 24'h00_0000;
                        busy <= 1'b1;
                        busy_cnt_reg <= BUSY_LOAD;
                    end
                end
            end else if (ready && cmd_reg == `SFWG_CMD_REG_WRITE && latch) begin
                if (hw_locked) begin
                    cmd_refused <= 1'b1;
                end else begin
                    // guard bits only while not frozen
                    status_reg[`SFWG_ST_LOCK] <= data_reg[`SFWG_ST_LOCK];
                    if (!frozen) begin
                        status_reg[`SFWG_ST_GUARD_LO+2:`SFWG_ST_GUARD_LO] <=
                            data_reg[`SFWG_ST_GUARD_LO+2:`SFWG_ST_GUARD_LO];
                    end
                    if (bit_cnt_reg == 16'd24 && !frozen) begin
                        // freeze and origin bits are sticky once set
                        // config is the second data byte, after status
                        config_reg[`SFWG_CF_FREEZE] <= 1'b1 & addr_reg[8+`SFWG_CF_FREEZE];
                        config_reg[`SFWG_CF_QUAD] <= addr_reg[8+`SFWG_CF_QUAD];
                        config_reg[`SFWG_CF_ORIGIN] <= config_reg[`SFWG_CF_ORIGIN] |
                            addr_reg[8+`SFWG_CF_ORIGIN];
                    end
                    busy <= 1'b1;
                    busy_cnt_reg <= BUSY_LOAD;
                end
            end else if (ready && bit_cnt_reg >= 16'd32 && latch && (is_prog || is_erase)) begin
                // only when latch set; else command has no effect
                if (prot || (is_param && UNIFORM_64K == 0) ||
                        (cmd_reg == `SFWG_CMD_BULK_ERASE)) begin
                    cmd_refused <= 1'b1;
                end else begin
                    // programming clears bits only; array model applies the and
                    prog_start <= is_prog;
                    erase_start <= is_erase;
                    op_cmd <= cmd_reg;
                    op_addr <= addr_reg;
                    busy <= 1'b1;
                    busy_cnt_reg <= BUSY_LOAD;
                end
            end else if (cs_rise && !whole && latch && (is_prog || is_erase ||
                    cmd_reg == `SFWG_CMD_REG_WRITE)) begin
                cmd_refused <= 1'b1;
            end
            // remembers the command that owns the current busy span
            if (ready) begin
                cur_cmd_reg <= cmd_reg;
            end
        end
    end
    // ****************************************
    // outputs and edge history
    // ****************************************
    always @(posedge clk) begin
        if (!resetn) begin
            cs_n_d_reg <= 1'b1;
            sck_d_reg <= 1'b0;
            pause_d_reg <= 1'b1;
            serial_out <= 1'b0;
            serial_out_en <= 1'b0;
            fast_prog_active <= 1'b0;
        end else begin
            cs_n_d_reg <= cs_n;
            sck_d_reg <= sck;
            pause_d_reg <= pause_pin;
            serial_out <= status_out_bit;
            serial_out_en <= !cs_n && !paused && !pause_enter;
            fast_prog_active <= busy && prog_start == 1'b0 && !quad && guard_pin &&
                (cur_cmd_reg == `SFWG_CMD_PAGE_PROG ||
                cur_cmd_reg == `SFWG_CMD_QUAD_PROG);
        end
    end
endmodule

// >>> sfwg_core_test.sv
// self-checking bench for the write guard and pause block
`timescale 1ns/10ps
module sfwg_core_test;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg write_guard_pin = 1'b1;
    reg status_out_bit = 1'b1;
    wire chip_select_n, serial_clk, serial_in, pause_n_pin, serial_out, serial_out_en;
    wire paused, busy, prog_start, erase_start, cmd_refused, fast_prog_active;
    wire [7:0] status_reg, config_reg, op_cmd;
    wire [23:0] op_addr;
    integer miscompares = 0;
    integer n_checks = 0;
    integer n_prog = 0;
    integer n_erase = 0;
    integer n_ref = 0;
    integer n_fast = 0;
    integer fast_mark = 0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        n_prog <= n_prog + prog_start;
        n_erase <= n_erase + erase_start;
        n_ref <= n_ref + cmd_refused;
        n_fast <= n_fast + fast_prog_active;
    end
    sfwg_host host_inst (.clk(clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .pause_n_pin(pause_n_pin));
    sfwg_core #(.BUSY_CYCLES(4), .UNIFORM_64K(1)) sfwg_core_inst (.clk(clk), .resetn(resetn),
        .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
        .pause_n_pin(pause_n_pin), .write_guard_pin(write_guard_pin),
        .status_out_bit(status_out_bit), .serial_out(serial_out), .serial_out_en(serial_out_en),
        .status_reg(status_reg), .config_reg(config_reg), .paused(paused), .busy(busy),
        .prog_start(prog_start), .erase_start(erase_start), .op_cmd(op_cmd), .op_addr(op_addr),
        .cmd_refused(cmd_refused), .fast_prog_active(fast_prog_active));
    task chk(input [8*8-1:0] name, input [23:0] exp, input [23:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task idle;
        integer k;
        begin
            for (k = 0; k < 200 && busy !== 1'b0; k = k + 1) @(posedge clk);
            #1;
        end
    endtask
    task unlock;
        host_inst.frame(40'h06, 8);
    endtask
    task rw(input [7:0] st, input [7:0] cf);
        begin
            unlock;
            host_inst.frame({8'h01, st, cf}, 24);
            idle;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // ****
    // test sequence
    // ****
    initial begin
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        host_inst.tick(3);
        chk("status", 24'h0, status_reg);
        host_inst.frame({8'h02, 24'h00_0100, 8'hA5}, 40);
        chk("prog", 24'h0, n_prog);
        unlock;
        chk("latch", 24'h1, status_reg[1]);
        host_inst.frame({8'h02, 24'h00_0100, 8'hA5}, 40);
        chk("prog", 24'h1, n_prog);
        chk("cmd", 24'h02, op_cmd);
        chk("addr", 24'h00_0100, op_addr);
        idle;
        chk("latch", 24'h0, status_reg[1]);
        chk("fast", 24'h1, n_fast != 0);
        $display("test program done");
        rw(8'h04, 8'h00);
        chk("guard", 24'h1, status_reg[4:2]);
        unlock;
        host_inst.frame({8'hD8, 24'hFC_0000}, 32);
        chk("refused", 24'h1, n_ref);
        chk("latch", 24'h1, status_reg[1]);
        host_inst.frame({8'hD8, 24'hFB_FFFF}, 32);
        chk("erase", 24'h1, n_erase);
        idle;
        unlock;
        host_inst.frame({8'h02, 24'h00_0200, 1'b1}, 33);
        chk("refused", 24'h2, n_ref);
        chk("prog", 24'h1, n_prog);
        host_inst.frame(40'h04, 8);
        chk("latch", 24'h0, status_reg[1]);
        $display("test guard done");
        host_inst.pins(1'b0, 1'b1);
        host_inst.tick(6);
        chk("out_en", 24'h1, serial_out_en);
        chk("out", 24'h1, serial_out);
        status_out_bit = 1'b0;
        host_inst.pins(1'b0, 1'b0);
        host_inst.tick(6);
        chk("paused", 24'h1, paused);
        chk("out", 24'h0, serial_out);
        chk("out_en", 24'h0, serial_out_en);
        host_inst.pins(1'b1, 1'b0);
        host_inst.tick(6);
        chk("paused", 24'h0, paused);
        host_inst.pins(1'b1, 1'b1);
        host_inst.pins(1'b0, 1'b1);
        host_inst.sclk(1'b1);
        host_inst.tick(4);
        host_inst.pins(1'b0, 1'b0);
        host_inst.tick(6);
        chk("paused", 24'h0, paused);
        host_inst.sclk(1'b0);
        host_inst.tick(6);
        chk("paused", 24'h1, paused);
        host_inst.pins(1'b0, 1'b1);
        host_inst.tick(6);
        chk("paused", 24'h0, paused);
        host_inst.pins(1'b0, 1'b0);
        host_inst.tick(6);
        host_inst.sclk(1'b1);
        host_inst.tick(4);
        host_inst.pins(1'b0, 1'b1);
        host_inst.tick(6);
        chk("paused", 24'h1, paused);
        host_inst.sclk(1'b0);
        host_inst.tick(6);
        chk("paused", 24'h0, paused);
        host_inst.pins(1'b1, 1'b1);
        rw(8'h00, 8'h02);
        host_inst.pins(1'b0, 1'b0);
        host_inst.tick(6);
        chk("paused", 24'h0, paused);
        host_inst.pins(1'b1, 1'b1);
        fast_mark = n_fast;
        unlock;
        host_inst.frame({8'h02, 24'h00_0300, 8'h5A}, 40);
        idle;
        chk("prog", 24'h2, n_prog);
        chk("fast", fast_mark, n_fast);
        rw(8'h00, 8'h00);
        chk("config", 24'h00, config_reg);
        $display("test pause done");
        rw(8'h84, 8'h21);
        chk("config", 24'h21, config_reg);
        chk("status", 24'h84, status_reg);
        unlock;
        host_inst.frame({8'hD8, 24'h03_FFFF}, 32);
        chk("refused", 24'h3, n_ref);
        host_inst.frame({8'hD8, 24'h04_0000}, 32);
        chk("erase", 24'h2, n_erase);
        idle;
        write_guard_pin = 1'b0;
        rw(8'h00, 8'h00);
        chk("refused", 24'h4, n_ref);
        chk("status", 24'h21, status_reg[7:2]);
        write_guard_pin = 1'b1;
        rw(8'h00, 8'h00);
        chk("status", 24'h04, status_reg);
        chk("config", 24'h21, config_reg);
        $display("test lock done");
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares = miscompares + 1;
        stop_test;
    end
endmodule
bind sfwg_core sfwg_guard_sva sfwg_guard_sva_inst (.clk(clk), .resetn(resetn),
    .status_reg(status_reg), .config_reg(config_reg), .paused(paused), .busy(busy),
    .prog_start(prog_start), .erase_start(erase_start), .op_addr(op_addr),
    .cmd_refused(cmd_refused), .fast_prog_active(fast_prog_active),
    .serial_out_en(serial_out_en));

// >>> sfwg_defines.vh
// constants for the serial flash write guard and pause block
`ifndef SFWG_DEFINES_VH
`define SFWG_DEFINES_VH
`define SFWG_CMD_WRITE_UNLOCK 8'h06
`define SFWG_CMD_WRITE_LOCK 8'h04
`define SFWG_CMD_REG_WRITE 8'h01
`define SFWG_CMD_PAGE_PROG 8'h02
`define SFWG_CMD_QUAD_PROG 8'h32
`define SFWG_CMD_SECT_ERASE 8'hD8
`define SFWG_CMD_BULK_ERASE 8'hC7
`define SFWG_CMD_P4K_ERASE 8'h20
`define SFWG_CMD_P8K_ERASE 8'h40
`define SFWG_CMD_OTP_PROG 8'h42
`define SFWG_ST_LATCH 1
`define SFWG_ST_GUARD_LO 2
`define SFWG_ST_LOCK 7
`define SFWG_CF_FREEZE 0
`define SFWG_CF_QUAD 1
`define SFWG_CF_ORIGIN 5
`define SFWG_ST_RESET 8'h00
`define SFWG_CF_RESET 8'h00
`define SFWG_TOP_1_64 24'hFC_0000
`define SFWG_BOT_1_64_END 24'h03_FFFF
`define SFWG_SECTOR_256K 24'h04_0000
`define SFWG_BUSY_CYCLES 16'h0010
`endif

// >>> sfwg_guard_sva.sv
// port assertions for the write guard and pause block
`timescale 1ns/10ps
module sfwg_guard_sva (
    input wire clk,
    input wire resetn,
    input wire [7:0] status_reg,
    input wire [7:0] config_reg,
    input wire paused,
    input wire busy,
    input wire prog_start,
    input wire erase_start,
    input wire [23:0] op_addr,
    input wire cmd_refused,
    input wire fast_prog_active,
    input wire serial_out_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire go = prog_start | erase_start;
    wire [2:0] code = status_reg[4:2];
    // guarded span doubles per code; code 7 covers all, code 0 guards nothing
    wire [24:0] span = 25'h004_0000 << (code - 3'h1);
    wire [24:0] addr = {1'b0, op_addr};
    wire top_hit = (code == 3'h7) | ((code != 3'h0) & (addr >= 25'h100_0000 - span));
    wire bot_hit = (code == 3'h7) | ((code != 3'h0) & (addr < span));
    a_start_has_latch: assert property (go |-> status_reg[1]) else $error("start without latch");
    a_start_sets_busy: assert property (go |-> ##[0:1] busy) else $error("start without busy");
    a_busy_end_clears: assert property ($fell(busy) |-> !status_reg[1]) else $error("latch kept");
    a_refuse_keeps_latch: assert property (cmd_refused |-> !go ##1 status_reg[1])
        else $error("refusal started or dropped latch");
    a_top_guard_hit: assert property (go && !config_reg[5] |-> !top_hit)
        else $error("top region written");
    a_bottom_guard_hit: assert property (go && config_reg[5] |-> !bot_hit)
        else $error("bottom region written");
    a_origin_stays_set: assert property ($past(config_reg[5]) |-> config_reg[5])
        else $error("origin cleared");
    a_freeze_stays_set: assert property ($past(config_reg[0]) |-> config_reg[0])
        else $error("freeze cleared");
    a_freeze_holds_guard: assert property ($past(config_reg[0]) |-> $stable(code) && $stable(config_reg[5]))
        else $error("frozen bits changed");
    a_quad_no_pause: assert property (config_reg[1] |-> !paused && !fast_prog_active)
        else $error("pause or fast program in quad");
    a_pause_output_off: assert property (paused |-> !serial_out_en) else $error("output driven");
endmodule

// >>> sfwg_host.sv
// host serial controller model driving the flash pins
`timescale 1ns/10ps
module sfwg_host (
    input wire clk,
    output reg chip_select_n,
    output reg serial_clk,
    output reg serial_in,
    output reg pause_n_pin
);
    integer i;
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
        pause_n_pin = 1'b1;
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // n bits msb first; serial clock rests low outside frames
    task frame(input [39:0] bits, input integer n);
        begin
            tick(1);
            chip_select_n = 1'b0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                serial_in = bits[i];
                tick(4);
                serial_clk = 1'b1;
                tick(4);
                serial_clk = 1'b0;
            end
            tick(4);
            chip_select_n = 1'b1;
            serial_in = ~serial_in;
            tick(12);
        end
    endtask
    task sclk(input s);
        begin
            tick(1);
            serial_clk = s;
        end
    endtask
    task pins(input c, input p);
        begin
            tick(1);
            chip_select_n = c;
            pause_n_pin = p;
        end
    endtask
endmodule

// >>> sfwg_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sfwg_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire resetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_reg;
    always @(posedge clk) begin
        if (!resetn) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
